/* File: common/link_event_pkg.sv */
// Contract
// - cycle start stamp differing from local seconds/cycle fields sets bit 23
// - no cycle start between two cycle-begin events sets bit 22
// - bit 22 may be set early by gap-based prediction of a lost cycle
// - change of seconds bit 6 (timer bit 31) sets bit 21
// - toggle of the cycle number low bit sets bit 20
// - line-layer status interrupt request sets bit 19
// - register access while link clock missing sets bit 18 before next access
// - line layer entering bus reset sets bit 17
// - end of node identification stream sets bit 16
// - bit 16 is cleared in the same cycle bit 17 is set
// - bit 15 sets with bit 16 and survives bus reset
// - bits 14 to 10 read as zero
// - atomic reply without completion acknowledge sets bit 9
// - host bus error on acknowledged deferred store sets bit 8
// - flags set on source edge (rising for link events, either edge for timer bits 31 and 12) or by writing one to set offset
// - flags clear only by writing one to the clear offset, except bit 16, which bus reset clears
// - event reads return flags ANDed with the mask register
package link_event_pkg;
	localparam logic [7:0] EVT_SET_OFS = 8'h80;
	localparam logic [7:0] EVT_CLR_OFS = 8'h84;
	localparam logic [7:0] MASK_SET_OFS = 8'h88;
	localparam logic [7:0] MASK_CLR_OFS = 8'h8c;
	localparam logic [7:0] RAW_OFS = 8'h90;

	localparam int MISMATCH_BIT = 23;
	localparam int LOST_BIT = 22;
	localparam int SEC64_BIT = 21;
	localparam int BEGIN_BIT = 20;
	localparam int PHYREQ_BIT = 19;
	localparam int ACCFAIL_BIT = 18;
	localparam int BUSRST_BIT = 17;
	localparam int IDDONE_BIT = 16;
	localparam int IDDONE2_BIT = 15;
	localparam int ATOMIC_BIT = 9;
	localparam int DEFER_BIT = 8;

	localparam logic [31:0] IMPL_BITS = 32'h00ff8300;
	localparam logic [31:0] FLAGS_RESET = 32'h00000000;
	localparam logic [31:0] MASK_RESET = 32'h00000000;

	localparam int SEC_HI = 31;
	localparam int SEC_LO = 25;
	localparam int CNT_HI = 24;
	localparam int CNT_LO = 12;
	localparam int SEC_TOGGLE_BIT = 31;
	localparam int CYCLE_LSB_BIT = 12;

	localparam int CORE_PERIOD_NS = 5;
	localparam int CLK_MISS_NS = 1000;
	localparam int CLK_MISS_CYC = (CLK_MISS_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	localparam int MISS_W = 8;

	typedef struct packed {
		logic cycleStart;
		logic subGap;
		logic arbGap;
		logic phyReq;
		logic busRst;
		logic selfIdDone;
		logic lockFail;
		logic postFail;
	} link_events_type;

	typedef struct packed {
		logic [6:0] seconds;
		logic [12:0] cycle;
	} stamp_type;

	typedef enum logic [2:0] {
		CW_IDLE = 3'b000,
		CW_OPEN = 3'b001,
		CW_GAPPED = 3'b010,
		CW_DONE = 3'b011,
		CW_LOST = 3'b100
	} cycle_watch_type;
endpackage

/* File: hw/edge_sync.sv */
module edge_sync #(
	parameter int W = 9
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [W-1:0] async,
	output logic [W-1:0] level,
	output logic [W-1:0] rise
);
	logic [W-1:0] stage1;
	logic [W-1:0] prev;

	// stage1 feeds only the second stage
	always_ff @(posedge core_clk) begin
		if (rst) begin
			stage1 <= '0;
			level <= '0;
			prev <= '0;
		end else begin
			stage1 <= async;
			level <= stage1;
			prev <= level;
		end
	end

	assign rise = level & ~prev;
endmodule

/* File: hw/link_cycle_bus_event_flags.sv */
// The implementer's own choices: register access over APB and the register offsets.
module link_cycle_bus_event_flags
	import link_event_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic linkClk,
	input wire link_events_type linkEvents,
	input wire stamp_type rxStamp,
	input wire logic [31:0] cycleTimer
);
	logic [31:0] flags;
	logic [31:0] mask;
	logic [31:0] next_flags;
	logic [31:0] hwSet;
	logic [31:0] swSet;
	logic [31:0] swClr;
	logic [31:0] strbMask;
	logic [31:0] maskedFlags;
	logic [31:0] readData;
	logic readOk;
	logic [8:0] syncLevel;
	logic [8:0] syncRise;
	link_events_type evRise;
	logic linkRise;
	stamp_type stampS1;
	stamp_type stampS2;
	logic stampMismatch;
	logic secPrev;
	logic cntPrev;
	logic sec64Pulse;
	logic cycleBegin;
	logic [MISS_W-1:0] missCount;
	logic clkMissing;
	logic accDone;
	logic wrDone;
	logic lostHit;
	cycle_watch_type watch;
	cycle_watch_type next_watch;

	// link clock and every link event cross through two flops
	edge_sync #(
		.W(9)
	) syncEvents (
		.core_clk(core_clk),
		.rst(rst),
		.async({linkClk, linkEvents}),
		.level(syncLevel),
		.rise(syncRise)
	);

	assign evRise = link_events_type'(syncRise[7:0]);
	assign linkRise = syncRise[8];

	// stamp is held steady by the link while its strobe is high
	always_ff @(posedge core_clk) begin
		if (rst) begin
			stampS1 <= '0;
			stampS2 <= '0;
		end else begin
			stampS1 <= rxStamp;
			stampS2 <= stampS1;
		end
	end

	assign stampMismatch = (stampS2.seconds != cycleTimer[SEC_HI:SEC_LO]) ||
		(stampS2.cycle != cycleTimer[CNT_HI:CNT_LO]);

	// cycle timer is on the core clock, no crossing needed
	always_ff @(posedge core_clk) begin
		if (rst) begin
			secPrev <= 1'b0;
			cntPrev <= 1'b0;
		end else begin
			secPrev <= cycleTimer[SEC_TOGGLE_BIT];
			cntPrev <= cycleTimer[CYCLE_LSB_BIT];
		end
	end

	assign sec64Pulse = secPrev ^ cycleTimer[SEC_TOGGLE_BIT];
	assign cycleBegin = cntPrev ^ cycleTimer[CYCLE_LSB_BIT];

	// lost-cycle watch: one verdict per cycle, prediction included
	always_comb begin
		next_watch = watch;
		lostHit = 1'b0;
		case (watch)
			CW_IDLE: begin
				if (cycleBegin) begin
					next_watch = CW_OPEN;
				end
			end
			CW_OPEN: begin
				if (cycleBegin) begin
					lostHit = 1'b1;
				end else if (evRise.cycleStart) begin
					next_watch = CW_DONE;
				end else if (evRise.arbGap) begin
					lostHit = 1'b1;
					next_watch = CW_LOST;
				end else if (evRise.subGap) begin
					next_watch = CW_GAPPED;
				end
			end
			CW_GAPPED: begin
				if (cycleBegin) begin
					lostHit = 1'b1;
					next_watch = CW_OPEN;
				end else if (evRise.cycleStart) begin
					next_watch = CW_DONE;
				end else if (evRise.subGap || evRise.arbGap) begin
					lostHit = 1'b1;
					next_watch = CW_LOST;
				end
			end
			CW_DONE: begin
				if (cycleBegin) begin
					next_watch = CW_OPEN;
				end
			end
			CW_LOST: begin
				// already reported; a late start must not re-flag
				if (cycleBegin) begin
					next_watch = CW_OPEN;
				end
			end
			default: begin
				next_watch = CW_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			watch <= CW_IDLE;
		end else begin
			watch <= next_watch;
		end
	end

	// link clock watchdog, saturating
	always_ff @(posedge core_clk) begin
		if (rst) begin
			missCount <= '0;
		end else if (linkRise) begin
			missCount <= '0;
		end else if (!clkMissing) begin
			missCount <= missCount + MISS_W'(1);
		end
	end

	assign clkMissing = (missCount == MISS_W'(CLK_MISS_CYC));

	// no wait states; the access phase edge completes the transfer
	assign accDone = psel && penable && pready;
	assign wrDone = accDone && pwrite && !pslverr;
	assign strbMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	assign maskedFlags = flags & mask;

	always_comb begin
		swSet = '0;
		swClr = '0;
		if (wrDone && paddr == EVT_SET_OFS) begin
			swSet = pwdata & strbMask;
		end else if (wrDone && paddr == EVT_CLR_OFS) begin
			swClr = pwdata & strbMask;
		end
	end

	always_comb begin
		hwSet = '0;
		hwSet[MISMATCH_BIT] = evRise.cycleStart && stampMismatch;
		hwSet[LOST_BIT] = lostHit;
		hwSet[SEC64_BIT] = sec64Pulse;
		hwSet[BEGIN_BIT] = cycleBegin;
		hwSet[PHYREQ_BIT] = evRise.phyReq;
		hwSet[ACCFAIL_BIT] = accDone && clkMissing;
		hwSet[BUSRST_BIT] = evRise.busRst;
		hwSet[IDDONE_BIT] = evRise.selfIdDone;
		hwSet[IDDONE2_BIT] = evRise.selfIdDone;
		hwSet[ATOMIC_BIT] = evRise.lockFail;
		hwSet[DEFER_BIT] = evRise.postFail;
	end

	// a source edge wins over a software clear in the same cycle
	always_comb begin
		next_flags = ((flags & ~swClr) | swSet | hwSet) & IMPL_BITS;
		if (evRise.busRst) begin
			next_flags[IDDONE_BIT] = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			flags <= FLAGS_RESET;
		end else begin
			flags <= next_flags;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mask <= MASK_RESET;
		end else if (wrDone && paddr == MASK_SET_OFS) begin
			mask <= (mask | (pwdata & strbMask)) & IMPL_BITS;
		end else if (wrDone && paddr == MASK_CLR_OFS) begin
			mask <= mask & ~(pwdata & strbMask);
		end
	end

	always_comb begin
		readData = '0;
		readOk = 1'b1;
		if (paddr == EVT_SET_OFS || paddr == EVT_CLR_OFS) begin
			readData = maskedFlags;
		end else if (paddr == MASK_SET_OFS || paddr == MASK_CLR_OFS) begin
			readData = mask;
		end else if (paddr == RAW_OFS) begin
			readData = flags;
		end else begin
			readOk = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (psel && !penable) begin
			pready <= 1'b1;
			pslverr <= !readOk;
			prdata <= pwrite ? 32'h00000000 : (readData & IMPL_BITS);
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// level interrupt trails the flags by one cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |maskedFlags;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	a_cycle_mismatch_set: assert property (
		evRise.cycleStart && stampMismatch |=> flags[MISMATCH_BIT]
	) else $error("mismatching cycle start did not set flag");

	a_lost_on_begin: assert property (
		cycleBegin && (watch == CW_OPEN || watch == CW_GAPPED) |=> flags[LOST_BIT]
	) else $error("lost cycle not flagged at next begin");

	a_lost_predicted: assert property (
		watch == CW_GAPPED && evRise.subGap && !cycleBegin && !evRise.cycleStart
		|=> flags[LOST_BIT] && watch == CW_LOST
	) else $error("predicted lost cycle not flagged");

	a_seconds_toggle: assert property (
		secPrev != cycleTimer[SEC_TOGGLE_BIT] |=> flags[SEC64_BIT]
	) else $error("seconds bit change not flagged");

	a_cycle_begin: assert property (
		cntPrev != cycleTimer[CYCLE_LSB_BIT] |=> flags[BEGIN_BIT]
	) else $error("cycle count toggle not flagged");

	a_phy_request: assert property (
		evRise.phyReq |=> flags[PHYREQ_BIT]
	) else $error("status request not flagged");

	a_access_fail: assert property (
		accDone && clkMissing |=> flags[ACCFAIL_BIT] && !pready
	) else $error("access fail not flagged before next access");

	a_bus_reset_done: assert property (
		evRise.busRst |=> flags[BUSRST_BIT] && !flags[IDDONE_BIT]
	) else $error("bus reset did not clear done flag");

	a_done_pair: assert property (
		evRise.selfIdDone && !evRise.busRst
		|=> flags[IDDONE_BIT] && flags[IDDONE2_BIT]
	) else $error("done flags not set together");

	a_sticky_kept: assert property (
		evRise.busRst && flags[IDDONE2_BIT] && !swClr[IDDONE2_BIT] |=> flags[IDDONE2_BIT]
	) else $error("secondary done lost on bus reset");

	a_reserved_zero: assert property (
		pready |-> prdata[14:10] == 5'h00 && flags[14:10] == 5'h00
	) else $error("reserved bits not zero");

	a_atomic_fail: assert property (
		evRise.lockFail |=> flags[ATOMIC_BIT]
	) else $error("atomic reply failure not flagged");

	a_store_fail: assert property (
		evRise.postFail |=> flags[DEFER_BIT]
	) else $error("deferred store failure not flagged");

	a_set_write: assert property (
		(swSet & IMPL_BITS) != 32'h0 && !evRise.busRst
		|=> (($past(swSet) & IMPL_BITS) & ~flags) == 32'h0
	) else $error("set write did not set flags");

	a_clear_only: assert property (
		swClr == 32'h0 && !evRise.busRst |=> ($past(flags) & ~flags) == 32'h0
	) else $error("flag cleared without clear write");

	a_read_masked: assert property (
		psel && !penable && !pwrite && paddr == EVT_SET_OFS
		|=> pready && prdata == $past(maskedFlags)
	) else $error("event read not masked");

	a_single_pulse: assert property (
		evRise.phyReq |=> !evRise.phyReq
	) else $error("source gave more than one pulse");
endmodule

/* File: sim/link_cycle_bus_event_flags_tb.sv */
module link_cycle_bus_event_flags_tb
	import link_event_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk, rst, psel, penable, pwrite, irq, pready, pslverr, linkClk;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, cycleTimer, rd, ex, mk, sv;
	logic [3:0] pstrb, sb;
	link_events_type linkEvents;
	stamp_type rxStamp;
	int errorCnt = 0;
	int cmpCount = 0;
	int seed = 85;

	link_phy_model phy (.linkClk(linkClk), .linkEvents(linkEvents), .rxStamp(rxStamp));
	link_cycle_bus_event_flags DUT (.core_clk(core_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .linkClk(linkClk), .linkEvents(linkEvents), .rxStamp(rxStamp),
		.cycleTimer(cycleTimer));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	task chk(input logic [31:0] got, input logic [31:0] e);
		cmpCount++;
		if (got !== e) begin
			errorCnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, e);
		end
	endtask
	// wait on pready is unbounded here; the watchdog cuts a hang
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] b);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		pstrb <= b;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		sv[0] = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e);
		xfer(a, 1'b0, '0, 4'hf);
		chk(rd, e);
	endtask
	task step(input logic [31:0] e);
		ex = e;
		rdchk(RAW_OFS, ex);
		chk({31'b0, irq}, {31'b0, |(ex & mk)});
	endtask
	task clr;
		xfer(EVT_CLR_OFS, 1'b1, '1, 4'hf);
		step('0);
	endtask
	task tick(input logic [31:0] flip);
		@(posedge core_clk);
		cycleTimer <= cycleTimer ^ flip;
		repeat (6) @(posedge core_clk);
	endtask
	function stamp_type stampOf(input logic [31:0] t);
		return {t[SEC_HI:SEC_LO], t[CNT_HI:CNT_LO]};
	endfunction
	function logic [31:0] lanes(input logic [3:0] b);
		return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
	endfunction

	task finalReport;
		$display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
		if (errorCnt == 0 && cmpCount > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		#200000;
		errorCnt++;
		finalReport;
	end

	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = '0;
		cycleTimer = '0;
		mk = MASK_RESET;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		step(FLAGS_RESET);
		rdchk(MASK_SET_OFS, MASK_RESET);
		xfer(MASK_SET_OFS, 1'b1, '1, 4'hf);
		mk = IMPL_BITS;
		rdchk(MASK_CLR_OFS, IMPL_BITS);
		xfer(EVT_SET_OFS, 1'b1, '1, 4'hf);
		step(IMPL_BITS);
		clr;
		$display("test registers done");
		phy.pulse(4);
		step(32'h1 << PHYREQ_BIT);
		phy.pulse(4);
		step(ex);
		phy.pulse(1);
		step(ex | (32'h1 << ATOMIC_BIT));
		phy.pulse(0);
		step(ex | (32'h1 << DEFER_BIT));
		rdchk(EVT_SET_OFS, ex);
		xfer(EVT_CLR_OFS, 1'b1, '1, 4'b0010);
		step(ex & ~32'h0000ff00);
		clr;
		phy.pulse(2);
		step((32'h1 << IDDONE_BIT) | (32'h1 << IDDONE2_BIT));
		phy.pulse(3);
		step((32'h1 << BUSRST_BIT) | (32'h1 << IDDONE2_BIT));
		clr;
		$display("test events done");
		@(posedge core_clk);
		cycleTimer <= $random(seed) & 32'h7fffefff;
		tick(32'h1 << CYCLE_LSB_BIT);
		step(32'h1 << BEGIN_BIT);
		phy.start(stampOf(cycleTimer));
		step(ex);
		clr;
		tick(32'h1 << CYCLE_LSB_BIT);
		phy.start(stampOf(cycleTimer) ^ (20'h1 << ($unsigned($random(seed)) % 20)));
		step((32'h1 << BEGIN_BIT) | (32'h1 << MISMATCH_BIT));
		clr;
		tick(32'h1 << CYCLE_LSB_BIT);
		step(32'h1 << BEGIN_BIT);
		tick(32'h1 << CYCLE_LSB_BIT);
		step(ex | (32'h1 << LOST_BIT));
		clr;
		tick(32'h1 << SEC_TOGGLE_BIT);
		step(32'h1 << SEC64_BIT);
		clr;
		// watch is still open here: no start since the last begin
		phy.pulse(5);
		step(32'h1 << LOST_BIT);
		clr;
		tick(32'h1 << CYCLE_LSB_BIT);
		phy.pulse(6);
		step(32'h1 << BEGIN_BIT);
		phy.pulse(6);
		step(ex | (32'h1 << LOST_BIT));
		// a late start after the prediction must not flag again
		phy.start(stampOf(cycleTimer));
		step(ex);
		clr;
		$display("test cycle timer done");
		for (int i = 0; i < 4; i++) begin
			xfer(MASK_CLR_OFS, 1'b1, '1, 4'hf);
			mk = $random(seed);
			xfer(MASK_SET_OFS, 1'b1, mk, 4'hf);
			mk = mk & IMPL_BITS;
			sv = $random(seed);
			sb = $random(seed);
			xfer(EVT_SET_OFS, 1'b1, sv, sb);
			ex = sv & lanes(sb) & IMPL_BITS;
			rdchk(EVT_CLR_OFS, ex & mk);
			step(ex);
			clr;
		end
		xfer(MASK_SET_OFS, 1'b1, '1, 4'hf);
		mk = IMPL_BITS;
		xfer(8'h40, 1'b0, '0, 4'hf);
		chk({31'b0, sv[0]}, 32'h1);
		$display("test random masks done");
		phy.clkOn = 1'b0;
		repeat (CLK_MISS_CYC + 20) @(posedge core_clk);
		xfer(RAW_OFS, 1'b0, '0, 4'hf);
		phy.clkOn = 1'b1;
		repeat (30) @(posedge core_clk);
		step(32'h1 << ACCFAIL_BIT);
		clr;
		$display("test link clock loss done");
		finalReport;
	end
endmodule

/* File: sim/link_phy_model.sv */
module link_phy_model
	import link_event_pkg::*;
(
	output logic linkClk,
	output link_events_type linkEvents,
	output stamp_type rxStamp
);
	timeunit 1ns;
	timeprecision 100ps;
	logic clkOn = 1'b1;
	// parked low while off: a stopped link clock never idles high
	initial begin
		linkClk = 1'b0;
		linkEvents = '0;
		rxStamp = '0;
		forever #24 linkClk = clkOn & ~linkClk;
	end
	// each level lasts 30 ns, long enough for the core to see it
	task automatic pulse(input int i);
		linkEvents[i] = 1'b1;
		#30;
		linkEvents[i] = 1'b0;
		#30;
	endtask
	task automatic start(input stamp_type st);
		rxStamp = st;
		#20;
		pulse(7);
		// stamp is stale once the start has gone
		rxStamp = ~st;
	endtask
endmodule
